// [wake_bus_status_regs.vh]
// Notes on behaviour
// - Bits 15 to 13 of the wake and bus status word always show the live wake input levels and no clear touches them.
// - Bits 12 to 7 latch the wake source, wake inputs 3, 2, 1, then CAN, LIN and the internal wake timer.
// - Bit 6 is set when the LIN bus stays dominant for longer than 12 ms.
// - Bit 5 is set and the LIN transmitter is disabled when the LIN transmit input stays dominant longer than 12 ms.
// - Bit 4 is set and the LIN transmitter is disabled when the LIN bus fails to follow the transmit input within 40 us.
// - Bit 3 is set and the CAN transmitter is disabled when the CAN receive output misses the transmit input 4 times.
// - Bit 2 is set and the CAN transmitter is disabled when the CAN bus misses the transmit input 4 times.
// - Bit 1 is set when the CAN bus stays dominant for longer than 700 us.
// - Bit 0 is set and the CAN transmitter is disabled when the CAN transmit input stays dominant longer than 700 us.
// - Bits 12 to 0 stay latched once set and only a read and clear access of this word releases them.
// - The thermal word is address 010011; the command byte is followed by data bits 15:8 and then bits 7:0.
// - The thermal word holds shutdown, warning, device state, regulator fail, restart count, watchdog misses, forced sleeps and watchdog state.
// - Wake levels, wake inputs, CAN and LIN wake go in the first data byte, timer wake and bus faults in the second.
// - The device state field records the state woken from: 01 regulator standby, 10 battery standby, 11 flash.
// - The restart field counts severe thermal restarts and seven of them force battery standby.
`ifndef WAKE_BUS_STATUS_REGS_VH
`define WAKE_BUS_STATUS_REGS_VH

// ========================================
// Serial frame
`define CMD_BITS 5'd8
`define FRAME_BITS 5'd24
`define LAST_BIT_IDX 5'd23
`define OP_READ_CLEAR 2'h2
`define ADDR_WAKE_BUS 6'h12
`define ADDR_THERMAL 6'h13

// ========================================
// Clear masks of latched bits
`define WB_CLEAR_MASK 16'h1fff
`define TS_CLEAR_MASK 16'hf80c

// ========================================
// Timing
`define CLK_MHZ 125
`define LIN_DOM_US 12000
`define LIN_FOLLOW_US 40
`define CAN_DOM_US 700
`define MISS_LIMIT 3'h4
`define RESTART_MAX 3'h7

// ========================================
// Synchroniser layout and reset levels
`define SYNC_W 11
`define SYNC_RST 11'h0fa
`define S_SCLK 0
`define S_CSN 1
`define S_MOSI 2
`define S_LIN_BUS 3
`define S_LIN_TXD 4
`define S_CAN_BUS 5
`define S_CAN_TXD 6
`define S_CAN_RXD 7
`define S_WAKE_LO 8
`define S_WAKE_HI 10

`endif

// [pin_sync_filter.v]
`timescale 1ns/10ps
// ========================================
// Three-stage pin synchroniser with agreement filter
module pin_sync_filter #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // Pins
    input wire [W-1:0] i_async,
    // Filtered levels
    output wire [W-1:0] o_stable
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            reg s1_q, s2_q, s3_q, st_q;
            // First stage feeds only the second
            always @(posedge i_core_clk)
            begin
                if (i_srst)
                begin
                    s1_q <= RST_VAL[g];
                    s2_q <= RST_VAL[g];
                    s3_q <= RST_VAL[g];
                    st_q <= RST_VAL[g];
                end
                else
                begin
                    s1_q <= i_async[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Change counts once stages two and three agree
                    if (s2_q == s3_q)
                        st_q <= s3_q;
                end
            end
            assign o_stable[g] = st_q;
        end
    endgenerate
endmodule // pin_sync_filter

// [wake_and_bus_fault_status.v]
`timescale 1ns/10ps
`include "wake_bus_status_regs.vh"
// ========================================
// Wake and bus fault status plus thermal status, serial readout
module wake_and_bus_fault_status #(
    parameter [23:0] LIN_DOM_CYC = `LIN_DOM_US * `CLK_MHZ,
    parameter [23:0] LIN_FOLLOW_CYC = `LIN_FOLLOW_US * `CLK_MHZ,
    parameter [23:0] CAN_DOM_CYC = `CAN_DOM_US * `CLK_MHZ
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // Serial control interface
    input wire i_spi_clk,
    input wire i_spi_cs_n,
    input wire i_spi_mosi,
    output reg o_spi_miso,
    output reg o_spi_miso_en,
    // Bus pins, low is dominant
    input wire i_lin_bus_level,
    input wire i_lin_transmit_input,
    input wire i_can_bus_level,
    input wire i_can_transmit_input,
    input wire i_can_receive_output,
    // Wake input pins, [2] is wake input 3
    input wire [2:0] i_wake_input_level,
    // Wake events: wu3, wu2, wu1, can, lin, timer
    input wire [5:0] i_wake_source_event,
    input wire [1:0] i_wake_from_state,
    // Thermal, regulator and watchdog events
    input wire i_thermal_shutdown_one,
    input wire i_thermal_warning,
    input wire i_primary_regulator_fail,
    input wire i_severe_thermal_shutdown,
    input wire i_restart_count_clear,
    input wire [3:0] i_watchdog_miss_count,
    input wire i_forced_sleep_by_watchdog,
    input wire i_forced_sleep_by_thermal_or_short,
    input wire [1:0] i_watchdog_counter_state,
    // Control outputs
    output reg o_lin_tx_disable,
    output reg o_can_tx_disable,
    output reg o_force_battery_standby
);
    // ========================================
    // Pin synchronisers
    wire [`SYNC_W-1:0] sync_in;
    wire [`SYNC_W-1:0] s;
    assign sync_in = {i_wake_input_level, i_can_receive_output,
        i_can_transmit_input, i_can_bus_level, i_lin_transmit_input,
        i_lin_bus_level, i_spi_mosi, i_spi_cs_n, i_spi_clk};

    pin_sync_filter #(
        .W(`SYNC_W),
        .RST_VAL(`SYNC_RST)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_async(sync_in),
        .o_stable(s)
    );

    // ========================================
    // Dominant time monitors
    // Conditions: lin bus, lin txd, lin not following, can bus, can txd
    wire [4:0] tm_cond;
    wire [4:0] tm_expired;
    wire [23:0] tm_lim [0:4];
    assign tm_cond[0] = ~s[`S_LIN_BUS];
    assign tm_cond[1] = ~s[`S_LIN_TXD];
    assign tm_cond[2] = ~s[`S_LIN_TXD] & s[`S_LIN_BUS];
    assign tm_cond[3] = ~s[`S_CAN_BUS];
    assign tm_cond[4] = ~s[`S_CAN_TXD];
    assign tm_lim[0] = LIN_DOM_CYC;
    assign tm_lim[1] = LIN_DOM_CYC;
    assign tm_lim[2] = LIN_FOLLOW_CYC;
    assign tm_lim[3] = CAN_DOM_CYC;
    assign tm_lim[4] = CAN_DOM_CYC;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_tm
            reg [23:0] cnt_q;
            // Saturates just past the limit, restarts when level returns
            always @(posedge i_core_clk)
            begin
                if (i_srst || !tm_cond[g])
                    cnt_q <= 24'h000000;
                else if (cnt_q <= tm_lim[g])
                    cnt_q <= cnt_q + 24'h000001;
            end
            // Longer than the limit, strictly
            assign tm_expired[g] = cnt_q > tm_lim[g];
        end
    endgenerate

    // ========================================
    // Follow monitors: [0] can receive output, [1] can bus
    reg can_txd_prev_q;
    wire can_txd_end;
    wire [1:0] follow;
    wire [1:0] miss_fault;
    assign can_txd_end = ~can_txd_prev_q & s[`S_CAN_TXD];
    assign follow[0] = ~s[`S_CAN_RXD];
    assign follow[1] = ~s[`S_CAN_BUS];

    always @(posedge i_core_clk)
    begin
        if (i_srst)
            can_txd_prev_q <= 1'b1;
        else
            can_txd_prev_q <= s[`S_CAN_TXD];
    end

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_fw
            reg seen_q;
            reg [2:0] miss_q;
            // A dominant txd pulse with no echo counts as one miss
            always @(posedge i_core_clk)
            begin
                if (i_srst)
                begin
                    seen_q <= 1'b0;
                    miss_q <= 3'h0;
                end
                else if (can_txd_end)
                begin
                    seen_q <= 1'b0;
                    if (seen_q)
                        miss_q <= 3'h0;
                    else if (miss_q != `MISS_LIMIT)
                        miss_q <= miss_q + 3'h1;
                end
                else if (~s[`S_CAN_TXD] && follow[g])
                    seen_q <= 1'b1;
            end
            assign miss_fault[g] = miss_q == `MISS_LIMIT;
        end
    endgenerate

    // ========================================
    // Serial frame decode
    reg sclk_prev_q, csn_prev_q;
    reg [4:0] bit_cnt_q;
    reg [7:0] cmd_q;
    reg [15:0] snap_q;
    reg clr_q;
    wire sclk_rise, sclk_fall, cs_fall, cs_rise;
    wire [7:0] cmd_next;
    wire [4:0] out_idx;
    wire [15:0] wb_word, ts_word;
    reg [15:0] sel_word;
    assign sclk_rise = s[`S_SCLK] & ~sclk_prev_q;
    assign sclk_fall = ~s[`S_SCLK] & sclk_prev_q;
    assign cs_fall = ~s[`S_CSN] & csn_prev_q;
    assign cs_rise = s[`S_CSN] & ~csn_prev_q;
    assign cmd_next = {cmd_q[6:0], s[`S_MOSI]};
    assign out_idx = `LAST_BIT_IDX - bit_cnt_q;

    // Word selected by the address in the command byte
    always @*
    begin
        case (cmd_next[5:0])
            `ADDR_WAKE_BUS: sel_word = wb_word;
            `ADDR_THERMAL: sel_word = ts_word;
            default: sel_word = 16'h0000;
        endcase
    end

    // Mode 0 framing: sample on rising, shift out on falling
    always @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            sclk_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
            bit_cnt_q <= 5'd0;
            cmd_q <= 8'h00;
            snap_q <= 16'h0000;
            clr_q <= 1'b0;
            o_spi_miso <= 1'b0;
            o_spi_miso_en <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= s[`S_SCLK];
            csn_prev_q <= s[`S_CSN];
            // Frame must be at least full length to clear anything
            clr_q <= cs_rise && bit_cnt_q == `FRAME_BITS &&
                cmd_q[7:6] == `OP_READ_CLEAR;
            if (cs_fall)
            begin
                bit_cnt_q <= 5'd0;
                cmd_q <= 8'h00;
                o_spi_miso <= 1'b0;
                o_spi_miso_en <= 1'b1;
            end
            else if (cs_rise)
                o_spi_miso_en <= 1'b0;
            else if (!s[`S_CSN])
            begin
                if (sclk_rise && bit_cnt_q < `FRAME_BITS)
                begin
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                    if (bit_cnt_q < `CMD_BITS)
                        cmd_q <= cmd_next;
                    // Snapshot taken as the command byte completes
                    if (bit_cnt_q == `CMD_BITS - 5'd1)
                        snap_q <= sel_word;
                end
                // High byte first, then low byte
                if (sclk_fall)
                begin
                    if (bit_cnt_q >= `CMD_BITS && bit_cnt_q < `FRAME_BITS)
                        o_spi_miso <= snap_q[out_idx[3:0]];
                    else
                        o_spi_miso <= 1'b0;
                end
            end
        end
    end

    // Only bits that were read are cleared, so later events survive
    wire clr_wb, clr_ts;
    wire [15:0] wb_clr, ts_clr;
    assign clr_wb = clr_q && cmd_q[5:0] == `ADDR_WAKE_BUS;
    assign clr_ts = clr_q && cmd_q[5:0] == `ADDR_THERMAL;
    assign wb_clr = clr_wb ? (snap_q & `WB_CLEAR_MASK) : 16'h0000;
    assign ts_clr = clr_ts ? (snap_q & `TS_CLEAR_MASK) : 16'h0000;

    // ========================================
    // Wake and bus fault word
    reg [5:0] wake_q;
    reg [6:0] fault_q;
    wire [5:0] wake_d;
    wire [6:0] fault_d;
    wire [6:0] fault_set;
    assign fault_set = {tm_expired[0],
        tm_expired[1],
        tm_expired[2],
        miss_fault[0],
        miss_fault[1],
        tm_expired[3],
        tm_expired[4]};
    // Set wins over a clear in the same cycle
    assign wake_d = (wake_q & ~wb_clr[12:7]) | i_wake_source_event;
    assign fault_d = (fault_q & ~wb_clr[6:0]) | fault_set;
    // Live levels first, no latch behind them
    assign wb_word = {s[`S_WAKE_HI:`S_WAKE_LO],
        wake_q, fault_q};

    always @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            wake_q <= 6'h00;
            fault_q <= 7'h00;
            o_lin_tx_disable <= 1'b0;
            o_can_tx_disable <= 1'b0;
        end
        else
        begin
            wake_q <= wake_d;
            fault_q <= fault_d;
            o_lin_tx_disable <= fault_d[5] | fault_d[4];
            o_can_tx_disable <= fault_d[3] | fault_d[2] | fault_d[0];
        end
    end

    // ========================================
    // Thermal, state and watchdog word
    reg thermal_shutdown_one_q, tw_q, primary_regulator_fail_q, fs_wd_q, fs_th_q;
    reg [1:0] state_q;
    reg [2:0] restart_q;
    wire any_wake;
    wire [2:0] restart_d;
    assign any_wake = |i_wake_source_event;
    assign restart_d = i_severe_thermal_shutdown ?
        ((restart_q == `RESTART_MAX) ? restart_q : restart_q + 3'h1) :
        (i_restart_count_clear ? 3'h0 : restart_q);
    assign ts_word = {thermal_shutdown_one_q, tw_q, state_q, primary_regulator_fail_q, restart_q,
        i_watchdog_miss_count, fs_wd_q, fs_th_q,
        i_watchdog_counter_state};

    always @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            thermal_shutdown_one_q <= 1'b0;
            tw_q <= 1'b0;
            primary_regulator_fail_q <= 1'b0;
            fs_wd_q <= 1'b0;
            fs_th_q <= 1'b0;
            state_q <= 2'h0;
            restart_q <= 3'h0;
            o_force_battery_standby <= 1'b0;
        end
        else
        begin
            thermal_shutdown_one_q <= (thermal_shutdown_one_q & ~ts_clr[15]) | i_thermal_shutdown_one;
            tw_q <= (tw_q & ~ts_clr[14]) | i_thermal_warning;
            primary_regulator_fail_q <= (primary_regulator_fail_q & ~ts_clr[11]) | i_primary_regulator_fail;
            fs_wd_q <= (fs_wd_q & ~ts_clr[3]) | i_forced_sleep_by_watchdog;
            fs_th_q <= (fs_th_q & ~ts_clr[2]) |
                i_forced_sleep_by_thermal_or_short;
            // Wake loads the state it left, beating a clear
            if (any_wake)
                state_q <= i_wake_from_state;
            else
                state_q <= state_q & ~ts_clr[13:12];
            restart_q <= restart_d;
            o_force_battery_standby <= restart_d == `RESTART_MAX;
        end
    end
endmodule // wake_and_bus_fault_status

// [wbfs_chk.sv]
`timescale 1ns/10ps
// ========================================
// Port checker for the status bank
module wbfs_chk #(
    parameter [23:0] LIN_DOM_CYC = 24'd40,
    parameter [23:0] LIN_FOLLOW_CYC = 24'd10,
    parameter [23:0] CAN_DOM_CYC = 24'd30
) (
    // Clock, reset and serial pins
    input wire i_core_clk,
    input wire i_srst,
    input wire i_spi_clk,
    input wire i_spi_cs_n,
    input wire o_spi_miso,
    input wire o_spi_miso_en,
    // Bus pins, events and controls
    input wire i_lin_bus_level,
    input wire i_lin_transmit_input,
    input wire i_can_transmit_input,
    input wire i_severe_thermal_shutdown,
    input wire i_restart_count_clear,
    input wire o_lin_tx_disable,
    input wire o_can_tx_disable,
    input wire o_force_battery_standby
);
    reg [23:0] lin_lo_q;
    reg [23:0] can_lo_q;
    reg [23:0] nf_q;
    reg [2:0] sev_q;
    // Run lengths at the pins; margin of 12 covers sync lag
    always @(posedge i_core_clk)
    begin
        lin_lo_q <= i_lin_transmit_input ? 24'h0 : lin_lo_q + 24'h1;
        can_lo_q <= i_can_transmit_input ? 24'h0 : can_lo_q + 24'h1;
        nf_q <= (i_lin_transmit_input | !i_lin_bus_level) ? 24'h0 :
            nf_q + 24'h1;
        if (i_srst | i_restart_count_clear)
            sev_q <= 3'h0;
        else if (i_severe_thermal_shutdown && sev_q != 3'h7)
            sev_q <= sev_q + 3'h1;
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);
    sequence cs_rise;
        $rose(i_spi_cs_n);
    endsequence
    sequence cs_held;
        !i_spi_cs_n [*6];
    endsequence
    a_lin_txd_dom: assert property (
        lin_lo_q == LIN_DOM_CYC + 24'd12 |-> o_lin_tx_disable)
        else $error("lin transmitter still enabled");
    a_lin_follow: assert property (
        nf_q == LIN_FOLLOW_CYC + 24'd12 |-> o_lin_tx_disable)
        else $error("lin follow fault missed");
    a_can_txd_dom: assert property (
        can_lo_q == CAN_DOM_CYC + 24'd12 |-> o_can_tx_disable)
        else $error("can transmitter still enabled");
    a_lin_kept: assert property ($fell(o_lin_tx_disable) |->
        $past(o_spi_miso_en) || $past(o_spi_miso_en, 2) ||
        $past(o_spi_miso_en, 3))
        else $error("lin disable dropped without a frame");
    a_en_on: assert property ($fell(i_spi_cs_n) |->
        ##[1:6] o_spi_miso_en)
        else $error("output enable late");
    a_en_off: assert property (cs_rise |-> ##[1:6] !o_spi_miso_en)
        else $error("output enable not released");
    a_en_hold: assert property (cs_held ##0 o_spi_miso_en |=>
        o_spi_miso_en)
        else $error("output enable dropped in frame");
    a_miso_edge: assert property (
        o_spi_miso_en && $changed(o_spi_miso) |-> !i_spi_clk)
        else $error("serial output moved while clock high");
    a_standby_seven: assert property (
        $rose(o_force_battery_standby) |-> sev_q == 3'h7)
        else $error("standby forced before seven restarts");
endmodule // wbfs_chk

bind wake_and_bus_fault_status wbfs_chk #(
    .LIN_DOM_CYC(LIN_DOM_CYC),
    .LIN_FOLLOW_CYC(LIN_FOLLOW_CYC),
    .CAN_DOM_CYC(CAN_DOM_CYC)
) wbfs_chk_inst (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_spi_clk(i_spi_clk),
    .i_spi_cs_n(i_spi_cs_n), .o_spi_miso(o_spi_miso),
    .o_spi_miso_en(o_spi_miso_en), .i_lin_bus_level(i_lin_bus_level),
    .i_lin_transmit_input(i_lin_transmit_input),
    .i_can_transmit_input(i_can_transmit_input),
    .i_severe_thermal_shutdown(i_severe_thermal_shutdown),
    .i_restart_count_clear(i_restart_count_clear),
    .o_lin_tx_disable(o_lin_tx_disable), .o_can_tx_disable(o_can_tx_disable),
    .o_force_battery_standby(o_force_battery_standby)
);

// [spi_host_model.sv]
`timescale 1ns/10ps
// ========================================
// Host side of the serial control link
module spi_host_model (
    // Serial pins
    output reg o_sclk,
    output reg o_cs_n,
    output reg o_mosi,
    input wire i_miso
);
    // Idle: clock low, deselected
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // One frame; the last 16 samples are the data word
    task xfer(input [23:0] tx, output [15:0] rx);
        integer i;
    begin
        o_cs_n = 1'b0;
        for (i = 23; i >= 0; i = i - 1)
        begin
            o_mosi = tx[i];
            #62.5 o_sclk = 1'b1;
            rx = {rx[14:0], i_miso};
            #62.5 o_sclk = 1'b0;
        end
        #62.5 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #300;
    end
    endtask
endmodule // spi_host_model

// [wake_and_bus_fault_status_test.sv]
`timescale 1ns/10ps
// ========================================
// Self-checking bench for the status bank
module wake_and_bus_fault_status_test;
    localparam [15:0] LV = 16'ha000;
    localparam [11:0] ST = 12'b01_10_11_01_10_11;
    reg clk, srst, lin_bus, lin_txd, can_bus, can_txd, can_rxd;
    reg ts1, tw, v1f, sev, rclr, fs_wd, fs_th;
    reg [2:0] wake_lvl;
    reg [5:0] wake_ev;
    reg [1:0] from_st, wd_state;
    reg [3:0] wd_miss;
    reg [15:0] rx;
    wire sclk, cs_n, mosi, miso, miso_en, lin_dis, can_dis, stby;
    integer err_count, checked, cyc, i;
    // Small limits keep fault runs short
    wake_and_bus_fault_status #(.LIN_DOM_CYC(24'd40),
        .LIN_FOLLOW_CYC(24'd10), .CAN_DOM_CYC(24'd30)
    ) wake_and_bus_fault_status_inst (
        .i_core_clk(clk), .i_srst(srst), .i_spi_clk(sclk),
        .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .o_spi_miso_en(miso_en), .i_lin_bus_level(lin_bus),
        .i_lin_transmit_input(lin_txd), .i_can_bus_level(can_bus),
        .i_can_transmit_input(can_txd), .i_can_receive_output(can_rxd),
        .i_wake_input_level(wake_lvl), .i_wake_source_event(wake_ev),
        .i_wake_from_state(from_st), .i_thermal_shutdown_one(ts1),
        .i_thermal_warning(tw), .i_primary_regulator_fail(v1f),
        .i_severe_thermal_shutdown(sev), .i_restart_count_clear(rclr),
        .i_watchdog_miss_count(wd_miss), .i_forced_sleep_by_watchdog(fs_wd),
        .i_forced_sleep_by_thermal_or_short(fs_th),
        .i_watchdog_counter_state(wd_state), .o_lin_tx_disable(lin_dis),
        .o_can_tx_disable(can_dis), .o_force_battery_standby(stby));
    spi_host_model spi_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .i_miso(miso));
    // Core clock, 8 ns
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task end_of_test;
    begin
        $display("mismatches %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task chk(input [8*12:1] name, input [15:0] e, input [15:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", name, e, g);
        end
    end
    endtask
    task wc(input integer n);
    begin
        repeat (n) @(posedge clk);
    end
    endtask
    // Bits 7:6 of the command set to 10 are the clearing code
    task rd(input [7:0] cmd, input [15:0] e);
    begin
        spi_host_model_inst.xfer({cmd, 16'h0}, rx);
        chk("status word", e, rx);
    end
    endtask
    // Pins: lin bus, lin txd, can bus, can txd, can rxd; then recessive
    task pat(input [4:0] v, input integer n);
    begin
        @(posedge clk) {lin_bus, lin_txd, can_bus, can_txd, can_rxd} <= v;
        wc(n);
        @(posedge clk) {lin_bus, lin_txd, can_bus, can_txd, can_rxd} <= 5'h1f;
        wc(8);
    end
    endtask
    task t_live;
    begin
        @(posedge clk) wake_lvl <= 3'b010;
        wc(8);
        rd(8'h92, 16'h4000);
        @(posedge clk) wake_lvl <= 3'b101;
        wc(8);
        rd(8'h3f, 16'h0000);
        chk("tx disables", 16'h0, {13'h0, lin_dis, can_dis, stby});
    end
    endtask
    // One wake source at a time, start states 11, 10, 01 in turn
    task t_wake;
    begin
        for (i = 0; i < 6; i = i + 1)
        begin
            @(posedge clk) from_st <= ST[2*i +: 2];
            wake_ev <= 6'h01 << i;
            @(posedge clk) wake_ev <= 6'h00;
            wc(2);
            rd(8'h93, {2'b00, ST[2*i +: 2], 12'h0});
            rd(8'h92, LV | (16'h0080 << i));
        end
        rd(8'h13, 16'h0000);
        rd(8'h12, LV);
    end
    endtask
    task t_lin;
    begin
        pat(5'b01111, 60);
        chk("lin disable", 16'h0, {15'h0, lin_dis});
        rd(8'h92, LV | 16'h0040);
        pat(5'b00111, 60);
        chk("lin disable", 16'h1, {15'h0, lin_dis});
        rd(8'h92, LV | 16'h0060);
        pat(5'b10111, 24);
        rd(8'h92, LV | 16'h0010);
        chk("lin disable", 16'h0, {15'h0, lin_dis});
    end
    endtask
    // A pulse echoed on one path restarts only that path's miss count
    task t_can;
    begin
        pat(5'b11011, 50);
        chk("can disable", 16'h0, {15'h0, can_dis});
        rd(8'h92, LV | 16'h0002);
        pat(5'b11000, 50);
        chk("can disable", 16'h1, {15'h0, can_dis});
        rd(8'h92, LV | 16'h0003);
        for (i = 0; i < 7; i = i + 1)
            pat(i == 3 ? 5'b11000 : 5'b11101, 8);
        rd(8'h92, LV);
        pat(5'b11100, 8);
        rd(8'h92, LV | 16'h0004);
        for (i = 0; i < 4; i = i + 1)
            pat(5'b11001, 8);
        chk("can disable", 16'h1, {15'h0, can_dis});
        // A count of four re-sets its bit until an echoed pulse
        pat(5'b11000, 8);
        rd(8'h92, LV | 16'h000c);
        chk("can disable", 16'h0, {15'h0, can_dis});
    end
    endtask
    // Eight restarts saturate the count at seven
    task t_therm;
    begin
        @(posedge clk) {ts1, tw, v1f, fs_wd, fs_th} <= 5'h1f;
        {wd_miss, wd_state, from_st, wake_ev} <= 14'h2981;
        @(posedge clk) {ts1, tw, v1f, fs_wd, fs_th} <= 5'h0;
        wake_ev <= 6'h00;
        for (i = 0; i < 8; i = i + 1)
        begin
            @(posedge clk) sev <= 1'b1;
            @(posedge clk) sev <= 1'b0;
        end
        wc(4);
        chk("standby", 16'h1, {15'h0, stby});
        rd(8'h93, 16'hefad);
        rd(8'h13, 16'h07a1);
        @(posedge clk) rclr <= 1'b1;
        @(posedge clk) rclr <= 1'b0;
        wc(4);
        chk("standby", 16'h0, {15'h0, stby});
        rd(8'h93, 16'h00a1);
        rd(8'h92, LV | 16'h0080);
    end
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_count = err_count + 1;
            end_of_test;
        end
    end
    initial
    begin
        err_count = 0;
        checked = 0;
        cyc = 0;
        srst = 1'b1;
        {lin_bus, lin_txd, can_bus, can_txd, can_rxd} = 5'h1f;
        {ts1, tw, v1f, sev, rclr, fs_wd, fs_th} = 7'h0;
        {wd_miss, wd_state, from_st, wake_ev} = 14'h0;
        wake_lvl = 3'b101;
        wc(11);
        @(posedge clk) srst <= 1'b0;
        wc(4);
        t_live;
        t_wake;
        t_lin;
        t_can;
        t_therm;
        end_of_test;
    end
endmodule // wake_and_bus_fault_status_test
